// *** hw/srap_device.sv ***
// Device end: serial register port with trim and calibration registers
// Function
// - Host holds select low for whole access
// - Sample data in on rising clock
// - No minimum clock rate, no timeouts
// - Frame is flag, address, data: 24 bits
// - All fields shift most significant bit first
// - Wide registers stored little-endian
// - Data out released during writes and header
// - First bit one reads, zero writes
// - Next fifteen bits are the address
// - Write stores final eight bits
// - Read drives register on final eight bits
// - Further bytes stream while select low
// - Address steps up or down per byte
// - Address hold stops address stepping
// - Host avoids access during calibration
// - Calibration never alters gain trims
// - Trims of absent inputs accessible, no effect
// - Separate offset trim per each of six cores
// - Offset plus background cal writes offset trims
// - Full scale common, gain trims per core
// - Host avoids offset trim writes under calibration
`timescale 1ns/1ps
module srap_device #(
   parameter int N_CH = 4
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Serial link
   srap_if.device link,
   // Calibration engine side
   input wire logic cal_busy_i,
   input wire logic cal_done_i,
   input wire logic [srap_pkg::N_CORES*8-1:0] cal_offset_i,
   // Trim outputs to analog
   output logic [srap_pkg::N_CORES*8-1:0] core_offset_trim_o,
   output logic [srap_pkg::N_CORES*8-1:0] core_gain_trim_o,
   output logic [srap_pkg::N_INPUTS*8-1:0] termination_trim_o,
   output logic [7:0] reference_voltage_trim_o,
   output logic [15:0] fullscale_adjust_o,
   output logic foreground_offset_cal_enable_o,
   output logic background_cal_enable_o,
   output logic write_strobe_o
);
   typedef struct packed {
      srap_pkg::srap_phase_t phase;
      logic [4:0] cnt;
      logic [2:0] bitn;
      logic [srap_pkg::ADDR_W-1:0] addr;
      logic [7:0] shift;
      logic [7:0] rd_data;
      logic sdo;
      logic sdo_oe;
      logic wstb;
      logic [7:0] ctrl;
      logic [7:0] cal;
      logic [15:0] fullscale;
      logic [7:0] refv;
      logic [srap_pkg::N_INPUTS*8-1:0] term;
      logic [srap_pkg::N_CORES*8-1:0] ofs;
      logic [srap_pkg::N_CORES*8-1:0] gain;
   } srap_dev_t;
   srap_dev_t st;
   srap_dev_t next_st;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   logic sel_n;
   logic sck_rise;
   logic sck_fall;
   logic sdi_s;
   srap_sync u_sync_sel (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_val_i(1'b1),
      .async_i(link.serial_select_n), .level_o(sel_n), .rise_o(), .fall_o());
   srap_sync u_sync_sck (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_val_i(1'b0),
      .async_i(link.sclk), .level_o(), .rise_o(sck_rise), .fall_o(sck_fall));
   srap_sync u_sync_sdi (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_val_i(1'b0),
      .async_i(link.sdi), .level_o(sdi_s), .rise_o(), .fall_o());

   // Register read mux, shared by first byte and streamed bytes
   function automatic logic [7:0] rd_reg(input srap_dev_t s, input logic [14:0] a);
      logic [7:0] r;
      r = srap_pkg::REG_ZERO;
      if (a == srap_pkg::ADDR_CTRL) r = s.ctrl;
      if (a == srap_pkg::ADDR_CAL) r = s.cal;
      if (a == srap_pkg::ADDR_FULLSCALE_LO) r = s.fullscale[7:0];
      if (a == srap_pkg::ADDR_FULLSCALE_HI) r = s.fullscale[15:8];
      if (a == srap_pkg::ADDR_REFV_TRIM) r = s.refv;
      for (int i = 0; i < srap_pkg::N_INPUTS; i++) begin
         if (a == srap_pkg::ADDR_TERM_TRIM + 15'(i)) r = s.term[i*8 +: 8];
      end
      for (int i = 0; i < srap_pkg::N_CORES; i++) begin
         if (a == srap_pkg::ADDR_OFFSET_TRIM + 15'(i)) r = s.ofs[i*8 +: 8];
         if (a == srap_pkg::ADDR_GAIN_TRIM + 15'(i)) r = s.gain[i*8 +: 8];
      end
      return r;
   endfunction

   // Next streaming address
   function automatic logic [14:0] step_addr(input logic [7:0] c, input logic [14:0] a);
      logic [14:0] r;
      r = a;
      if (!c[srap_pkg::BIT_HOLD]) begin
         r = c[srap_pkg::BIT_DIR_UP] ? a + 15'h0001 : a - 15'h0001;
      end
      return r;
   endfunction

   always_comb begin
      logic [7:0] wbyte;
      wbyte = {st.shift[6:0], sdi_s};
      next_st = st;
      next_st.wstb = 1'b0;
      if (sel_n) begin
         // Abort: any frame in flight is dropped
         next_st.phase = srap_pkg::SR_HDR;
         next_st.cnt = '0;
         next_st.bitn = '0;
         next_st.sdo_oe = 1'b0;
      end else if (sck_rise) begin
         next_st.shift = wbyte;
         case (st.phase)
            srap_pkg::SR_HDR: begin
               next_st.cnt = st.cnt + 5'h01;
               if (st.cnt == CNT_ZERO) begin
                  // Park the flag here; it sits in the top bit when the last address bit arrives
                  next_st.addr = {{(srap_pkg::ADDR_W-1){1'b0}}, sdi_s};
               end else begin
                  next_st.addr = {st.addr[13:0], sdi_s};
               end
               if (st.cnt == srap_pkg::CNT_HDR_LAST) begin
                  next_st.phase = st.addr[srap_pkg::ADDR_W-1] == 1'b1
                     ? srap_pkg::SR_RD : srap_pkg::SR_WR;
                  next_st.bitn = '0;
                  next_st.rd_data = rd_reg(st, {st.addr[13:0], sdi_s});
               end
            end
            srap_pkg::SR_WR: begin
               next_st.bitn = st.bitn + 3'h1;
               if (st.bitn == srap_pkg::BIT_LAST) begin
                  next_st.wstb = 1'b1;
                  next_st.addr = step_addr(st.ctrl, st.addr);
                  if (st.addr == srap_pkg::ADDR_CTRL) next_st.ctrl = wbyte;
                  if (st.addr == srap_pkg::ADDR_CAL) next_st.cal = wbyte;
                  if (st.addr == srap_pkg::ADDR_FULLSCALE_LO) next_st.fullscale[7:0] = wbyte;
                  if (st.addr == srap_pkg::ADDR_FULLSCALE_HI) next_st.fullscale[15:8] = wbyte;
                  if (st.addr == srap_pkg::ADDR_REFV_TRIM) next_st.refv = wbyte;
                  for (int i = 0; i < srap_pkg::N_INPUTS; i++) begin
                     if (st.addr == srap_pkg::ADDR_TERM_TRIM + 15'(i)) next_st.term[i*8 +: 8] = wbyte;
                  end
                  for (int i = 0; i < srap_pkg::N_CORES; i++) begin
                     if (st.addr == srap_pkg::ADDR_OFFSET_TRIM + 15'(i)) next_st.ofs[i*8 +: 8] = wbyte;
                     if (st.addr == srap_pkg::ADDR_GAIN_TRIM + 15'(i)) next_st.gain[i*8 +: 8] = wbyte;
                  end
               end
            end
            srap_pkg::SR_RD: begin
               // Input bits ignored during read data
               next_st.bitn = st.bitn + 3'h1;
               if (st.bitn == srap_pkg::BIT_LAST) begin
                  next_st.addr = step_addr(st.ctrl, st.addr);
                  next_st.rd_data = rd_reg(st, step_addr(st.ctrl, st.addr));
               end
            end
            default: next_st.phase = srap_pkg::SR_HDR;
         endcase
      end else if (sck_fall && st.phase == srap_pkg::SR_RD) begin
         next_st.sdo_oe = 1'b1;
         next_st.sdo = st.rd_data[srap_pkg::BIT_LAST - st.bitn];
      end
      if (st.phase != srap_pkg::SR_RD) next_st.sdo_oe = 1'b0;
      // Calibration loads offset trims only; gains untouched
      if (cal_done_i && st.cal[srap_pkg::BIT_FOREGROUND_OFFSET_CAL_ENABLE] && st.cal[srap_pkg::BIT_BACKGROUND_CAL_ENABLE]) begin
         next_st.ofs = cal_offset_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st <= '{phase: srap_pkg::SR_HDR, cnt: '0, bitn: '0, addr: '0, shift: '0,
            rd_data: '0, sdo: 1'b0, sdo_oe: 1'b0, wstb: 1'b0, ctrl: srap_pkg::CTRL_RESET,
            cal: srap_pkg::CAL_RESET, fullscale: srap_pkg::FULLSCALE_RESET,
            refv: srap_pkg::TRIM_RESET, term: {srap_pkg::N_INPUTS{srap_pkg::TRIM_RESET}},
            ofs: {srap_pkg::N_CORES{srap_pkg::TRIM_RESET}},
            gain: {srap_pkg::N_CORES{srap_pkg::TRIM_RESET}}};
      end else begin
         st <= next_st;
      end
   end

   assign link.sdo = st.sdo;
   assign link.sdo_oe = st.sdo_oe;
   assign core_offset_trim_o = st.ofs;
   assign core_gain_trim_o = st.gain;
   // Inputs beyond N_CH read back but never reach the analog side
   generate
      for (genvar g = 0; g < srap_pkg::N_INPUTS; g++) begin : g_term
         assign termination_trim_o[g*8 +: 8] = (g < N_CH) ? st.term[g*8 +: 8]
            : srap_pkg::TRIM_RESET;
      end
   endgenerate
   assign reference_voltage_trim_o = st.refv;
   assign fullscale_adjust_o = st.fullscale;
   assign foreground_offset_cal_enable_o = st.cal[srap_pkg::BIT_FOREGROUND_OFFSET_CAL_ENABLE];
   assign background_cal_enable_o = st.cal[srap_pkg::BIT_BACKGROUND_CAL_ENABLE];
   assign write_strobe_o = st.wstb;
   logic unused;
   assign unused = cal_busy_i;
endmodule

// *** hw/srap_host.sv ***
// Host end: serial master that runs single or streamed accesses
`timescale 1ns/1ps
module srap_host #(
   parameter int DIV = srap_pkg::HOST_DIV
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Command
   input wire logic start_i,
   input wire logic read_i,
   input wire logic [srap_pkg::ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic more_i,
   input wire logic cal_busy_i,
   output logic busy_o,
   output logic byte_done_o,
   output logic [7:0] rdata_o,
   // Serial link
   srap_if.host link
);
   typedef struct packed {
      logic act;
      logic [7:0] div;
      logic sck;
      logic [5:0] cnt;
      logic [23:0] tx;
      logic [7:0] rx;
      logic [7:0] rdata;
      logic done;
      logic rd;
   } srap_host_t;
   srap_host_t st;
   srap_host_t next_st;
   logic sdo_s;
   srap_sync u_sync_sdo (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_val_i(1'b0),
      .async_i(link.sdo), .level_o(sdo_s), .rise_o(), .fall_o());
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      if (!st.act) begin
         // No start while calibration runs
         if (start_i && !cal_busy_i) begin
            next_st.act = 1'b1;
            next_st.tx = {read_i, addr_i, wdata_i};
            next_st.cnt = '0;
            next_st.div = '0;
            next_st.sck = 1'b0;
            next_st.rd = read_i;
         end
      end else if (st.div == 8'(DIV - 1)) begin
         next_st.div = '0;
         next_st.sck = ~st.sck;
         if (st.sck) begin
            // Sample at the end of the high phase: the read bit needs both
            // synchronisers plus the device's own latency to arrive
            next_st.rx = {st.rx[6:0], sdo_s};
            next_st.tx = {st.tx[22:0], 1'b0};
            next_st.cnt = st.cnt + 6'h01;
            if (st.cnt == 6'(srap_pkg::FRAME_BITS - 1)) begin
               next_st.done = 1'b1;
               next_st.rdata = {st.rx[6:0], sdo_s};
               if (more_i) begin
                  next_st.cnt = 6'(srap_pkg::HDR_BITS);
                  next_st.tx = {wdata_i, 16'h0000};
               end else begin
                  next_st.act = 1'b0;
               end
            end
         end
      end else begin
         next_st.div = st.div + 8'h01;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st <= '{act: 1'b0, div: '0, sck: 1'b0, cnt: '0, tx: '0, rx: '0,
            rdata: '0, done: 1'b0, rd: 1'b0};
      end else begin
         st <= next_st;
      end
   end
   assign link.sclk = st.sck;
   assign link.serial_select_n = ~st.act;
   assign link.sdi = st.tx[23];
   assign busy_o = st.act;
   assign byte_done_o = st.done;
   assign rdata_o = st.rdata;
   logic unused;
   assign unused = link.sdo_oe ^ st.rd;
endmodule

// *** hw/srap_if.sv ***
// Four-wire serial link between host and device
`timescale 1ns/1ps
interface srap_if;
   logic sclk;
   logic serial_select_n;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   modport device (input sclk, input serial_select_n, input sdi, output sdo, output sdo_oe);
   modport host (output sclk, output serial_select_n, output sdi, input sdo, input sdo_oe);
endinterface

// *** hw/srap_pkg.sv ***
// Shared constants and types for the serial register access port
package srap_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;
   localparam int FRAME_BITS = 24;
   localparam int HDR_BITS = 16;
   localparam logic [4:0] CNT_HDR_LAST = 5'h0F;
   localparam logic [4:0] CNT_FRAME_LAST = 5'h17;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int N_CORES = 6;
   localparam int N_INPUTS = 4;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 15'h0010;
   localparam logic [ADDR_W-1:0] ADDR_CAL = 15'h0061;
   localparam logic [ADDR_W-1:0] ADDR_FULLSCALE_LO = 15'h0030;
   localparam logic [ADDR_W-1:0] ADDR_FULLSCALE_HI = 15'h0031;
   localparam logic [ADDR_W-1:0] ADDR_REFV_TRIM = 15'h007C;
   localparam logic [ADDR_W-1:0] ADDR_TERM_TRIM = 15'h007E;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET_TRIM = 15'h0100;
   localparam logic [ADDR_W-1:0] ADDR_GAIN_TRIM = 15'h0110;
   localparam int BIT_DIR_UP = 5;
   localparam int BIT_HOLD = 3;
   localparam int BIT_BACKGROUND_CAL_ENABLE = 1;
   localparam int BIT_FOREGROUND_OFFSET_CAL_ENABLE = 2;
   localparam logic [7:0] CTRL_RESET = 8'h20;
   localparam logic [7:0] CAL_RESET = 8'h00;
   localparam logic [15:0] FULLSCALE_RESET = 16'hA000;
   localparam logic [7:0] TRIM_RESET = 8'h80;
   localparam logic [7:0] REG_ZERO = 8'h00;
   localparam int HOST_DIV = 4;
   typedef enum logic [1:0] {SR_HDR, SR_WR, SR_RD} srap_phase_t;
endpackage

// *** hw/srap_sync.sv ***
// Two-flop synchroniser with rise and fall detect on the synced level
`timescale 1ns/1ps
module srap_sync (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic reset_val_i,
   // Async level in
   input wire logic async_i,
   // Synced level and edges
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } srap_sync_t;
   srap_sync_t st;
   srap_sync_t next_st;
   always_comb begin
      next_st = st;
      next_st.s1 = async_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         // Start at the pin's idle level so no false edge follows reset
         st <= '{s1: reset_val_i, s2: reset_val_i, s3: reset_val_i};
      end else begin
         st <= next_st;
      end
   end
   assign level_o = st.s2;
   assign rise_o = st.s2 & ~st.s3;
   assign fall_o = ~st.s2 & st.s3;
endmodule

// *** verif/srap_link_sva.sv ***
// Wire-level checks on the host to device serial link
`timescale 1ns/1ps
module srap_link_sva (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Link
   input wire logic sclk,
   input wire logic serial_select_n,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic sclk_q;
   logic rd;
   logic [5:0] cnt;
   wire logic rise = sclk & ~sclk_q;
   // Rising clock count and access type of the current frame
   always_ff @(posedge sys_clk_i) begin
      sclk_q <= sclk;
      if (rst_i || serial_select_n) begin
         cnt <= 6'h00;
         rd <= 1'b0;
      end else if (rise) begin
         if (cnt == 6'h00) rd <= sdi;
         if (cnt != 6'h3F) cnt <= cnt + 6'h01;
      end
   end
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_in_frame;
      !serial_select_n && cnt >= 6'h02;
   endsequence
   sequence s_data_phase;
      !serial_select_n && cnt >= 6'h11;
   endsequence
   chk_oe_write_off: assert property (s_in_frame ##0 !rd |-> !sdo_oe)
      else $error("data out driven in write frame");
   chk_oe_header_off: assert property (s_in_frame ##0 cnt <= 6'h0F |-> !sdo_oe)
      else $error("data out driven in header");
   chk_oe_read_on: assert property (s_data_phase ##0 rd |-> sdo_oe)
      else $error("data out not driven in read data");
   chk_oe_release: assert property ($rose(serial_select_n) |-> ##[0:4] !sdo_oe)
      else $error("data out not released after select");
   chk_sdo_hold_high: assert property (sdo_oe && sclk && $past(sclk) && $past(sclk, 2)
      |-> $stable(sdo))
      else $error("data out moved while clock high");
   chk_sdi_hold_high: assert property (sclk && $past(sclk) |-> $stable(sdi))
      else $error("data in moved while clock high");
   chk_rise_selected: assert property (rise |-> !serial_select_n)
      else $error("clock rise without select");
   chk_frame_whole: assert property ($rose(serial_select_n)
      |-> cnt >= 6'h18 && cnt[2:0] == 3'h0)
      else $error("frame not whole bytes");
endmodule

// *** verif/tb_serial_register_access_port.sv ***
// Testbench joining host and device ends over the serial link
`timescale 1ns/1ps
module tb_serial_register_access_port;
   logic sys_clk_i, rst_i, start_i, read_i, more_i, cal_busy_i, cal_done_i;
   logic [14:0] addr_i;
   logic [7:0] wdata_i, rdata_o, refv, d2_refv;
   logic busy_o, byte_done_o, fg_en, bg_en, strobe;
   logic [47:0] cal_offset_i, ofs, gain;
   logic [15:0] fs;
   logic [31:0] d2_term;
   logic bb_sclk, bb_sel_n, bb_sdi;
   logic [23:0] cap;
   int fail_count, compares, cycles, strobes;
   srap_if link();
   srap_if link2();
   assign link2.sclk = bb_sclk;
   assign link2.serial_select_n = bb_sel_n;
   assign link2.sdi = bb_sdi;
   srap_host srap_host_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start_i),
      .read_i(read_i), .addr_i(addr_i), .wdata_i(wdata_i), .more_i(more_i),
      .cal_busy_i(cal_busy_i), .busy_o(busy_o), .byte_done_o(byte_done_o),
      .rdata_o(rdata_o), .link(link));
   srap_device srap_device_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .link(link),
      .cal_busy_i(cal_busy_i), .cal_done_i(cal_done_i), .cal_offset_i(cal_offset_i),
      .core_offset_trim_o(ofs), .core_gain_trim_o(gain), .termination_trim_o(),
      .reference_voltage_trim_o(refv), .fullscale_adjust_o(fs),
      .foreground_offset_cal_enable_o(fg_en), .background_cal_enable_o(bg_en),
      .write_strobe_o(strobe));
   // Two-input variant driven bit by bit from the bench
   srap_device #(.N_CH(2)) srap_device_n2_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .link(link2), .cal_busy_i(1'b0), .cal_done_i(1'b0), .cal_offset_i(48'h0),
      .core_offset_trim_o(), .core_gain_trim_o(), .termination_trim_o(d2_term),
      .reference_voltage_trim_o(d2_refv), .fullscale_adjust_o(),
      .foreground_offset_cal_enable_o(), .background_cal_enable_o(), .write_strobe_o());
   srap_link_sva srap_link_sva_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk(link.sclk),
      .serial_select_n(link.serial_select_n), .sdi(link.sdi), .sdo(link.sdo),
      .sdo_oe(link.sdo_oe));
   always #25 sys_clk_i = ~sys_clk_i;
   // Frame as seen on the wire
   always @(posedge link.sclk) if (!link.serial_select_n) cap <= {cap[22:0], link.sdi};
   always @(posedge sys_clk_i) begin
      if (strobe === 1'b1) strobes++;
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check_val(input string what, input logic [47:0] exp, input logic [47:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One host access of n bytes, read bytes returned low byte first
   task automatic host_run(input logic rd, input logic [14:0] a, input logic [7:0] d,
         input int n, output logic [15:0] got);
      int k;
      int w;
      k = 0;
      w = 0;
      got = 16'h0000;
      read_i = rd;
      addr_i = a;
      wdata_i = d;
      more_i = n > 1;
      start_i = 1'b1;
      @(negedge sys_clk_i);
      start_i = 1'b0;
      while ((k < n || busy_o !== 1'b0) && w < 2000) begin
         @(negedge sys_clk_i);
         w++;
         if (byte_done_o === 1'b1) begin
            got[k*8+:8] = rdata_o;
            k++;
            more_i = 1'b0;
         end
      end
      repeat (6) @(negedge sys_clk_i);
      check_val("byte count", 48'(n), 48'(k));
   endtask
   task automatic bb_bits(input logic [23:0] v, input int n, input int half);
      for (int i = 23; i > 23 - n; i--) begin
         bb_sdi = v[i];
         repeat (half) @(negedge sys_clk_i);
         bb_sclk = 1'b1;
         repeat (half) @(negedge sys_clk_i);
         bb_sclk = 1'b0;
      end
   endtask
   task automatic bb_frame(input logic [23:0] v, input int n, input int half);
      bb_sel_n = 1'b0;
      bb_bits(v, n, half);
      repeat (4) @(negedge sys_clk_i);
      bb_sel_n = 1'b1;
      bb_sdi = ~bb_sdi;
      repeat (8) @(negedge sys_clk_i);
   endtask
   task automatic t_reset;
      check_val("fullscale", 48'(srap_pkg::FULLSCALE_RESET), 48'(fs));
      check_val("gain", {6{srap_pkg::TRIM_RESET}}, gain);
      check_val("oe", 48'h0, 48'(link.sdo_oe));
      $display("reset test done");
   endtask
   task automatic t_single;
      logic [15:0] g;
      host_run(1'b0, srap_pkg::ADDR_REFV_TRIM, 8'h3C, 1, g);
      check_val("refv", 48'h3C, 48'(refv));
      check_val("wire", {25'h0, srap_pkg::ADDR_REFV_TRIM, 8'h3C}, 48'(cap));
      check_val("strobes", 48'h1, 48'(strobes));
      host_run(1'b1, srap_pkg::ADDR_REFV_TRIM, 8'hC3, 1, g);
      check_val("wire rd", {25'h1, srap_pkg::ADDR_REFV_TRIM, 8'hC3}, 48'(cap));
      check_val("rdata", 48'h3C, 48'(g[7:0]));
      check_val("refv kept", 48'h3C, 48'(refv));
      $display("single test done");
   endtask
   task automatic t_stream;
      logic [15:0] g;
      host_run(1'b1, srap_pkg::ADDR_FULLSCALE_LO, 8'h00, 2, g);
      check_val("fs read", 48'(srap_pkg::FULLSCALE_RESET), 48'(g));
      host_run(1'b0, srap_pkg::ADDR_OFFSET_TRIM, 8'h5A, 2, g);
      check_val("ofs up", 48'h805A5A, 48'(ofs[23:0]));
      host_run(1'b0, srap_pkg::ADDR_CTRL, 8'h00, 1, g);
      host_run(1'b0, srap_pkg::ADDR_OFFSET_TRIM + 15'h0005, 8'h11, 2, g);
      check_val("ofs down", 48'h111180, 48'(ofs[47:24]));
      host_run(1'b0, srap_pkg::ADDR_CTRL, 8'h08, 1, g);
      host_run(1'b0, srap_pkg::ADDR_GAIN_TRIM, 8'h22, 2, g);
      check_val("gain hold", 48'h8022, 48'(gain[15:0]));
      $display("stream test done");
   endtask
   task automatic t_cal;
      logic [15:0] g;
      cal_offset_i = 48'h0C0B0A090807;
      cal_done_i = 1'b1;
      @(negedge sys_clk_i);
      cal_done_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      check_val("ofs no cal", 48'h111180805A5A, ofs);
      host_run(1'b0, srap_pkg::ADDR_CAL, 8'h06, 1, g);
      check_val("cal en", 48'h3, 48'({fg_en, bg_en}));
      cal_offset_i = 48'h0C0B0A090807;
      cal_done_i = 1'b1;
      @(negedge sys_clk_i);
      cal_done_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      check_val("ofs cal", 48'h0C0B0A090807, ofs);
      check_val("gain cal", 48'h808080808022, gain);
      cal_busy_i = 1'b1;
      start_i = 1'b1;
      @(negedge sys_clk_i);
      start_i = 1'b0;
      repeat (20) @(negedge sys_clk_i);
      check_val("busy in cal", 48'h0, 48'(busy_o));
      $display("cal test done");
   endtask
   task automatic t_abort;
      bb_frame({1'b0, srap_pkg::ADDR_REFV_TRIM, 8'hFF}, 10, 4);
      bb_frame({1'b0, srap_pkg::ADDR_REFV_TRIM, 8'h5C}, 24, 40);
      check_val("abort", 48'h5C, 48'(d2_refv));
      bb_bits({1'b0, srap_pkg::ADDR_REFV_TRIM, 8'hEE}, 24, 4);
      check_val("unselected", 48'h5C, 48'(d2_refv));
      bb_frame({1'b0, srap_pkg::ADDR_TERM_TRIM + 15'h0003, 8'h11}, 24, 4);
      check_val("absent term", 48'h80, 48'(d2_term[31:24]));
      $display("abort test done");
   endtask
   initial begin
      sys_clk_i = 1'b0;
      rst_i = 1'b1;
      {start_i, read_i, more_i, cal_busy_i, cal_done_i} = 5'h00;
      addr_i = 15'h0000;
      wdata_i = 8'h00;
      cal_offset_i = 48'h0;
      {bb_sclk, bb_sel_n, bb_sdi} = 3'h2;
      {fail_count, compares, cycles, strobes} = {4{32'h0}};
      repeat (3) @(negedge sys_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge sys_clk_i);
      t_reset();
      t_single();
      t_stream();
      t_cal();
      t_abort();
      stop_test();
   end
endmodule
